// ==== rtl/iaa_pkg.sv ====
package iaa_pkg;

  // sizes of the acknowledge datapath
  localparam int unsigned N_MOD  = 4;
  localparam int unsigned N_SRC  = N_MOD + 1;
  localparam int unsigned SIM_IX = N_MOD;
  localparam int unsigned ARB_W  = 4;
  localparam int unsigned LVL_W  = 3;
  localparam int unsigned VEC_W  = 8;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned VADR_W = VEC_W + 2;

  // arbitration field reset values
  localparam logic [ARB_W-1:0] ARB_SIM_RST = 4'hf;
  localparam logic [ARB_W-1:0] ARB_MOD_RST = 4'h0;
  localparam logic [ARB_W-1:0] ARB_NONE    = 4'h0;
  localparam logic [1:0]       ARB_MSB     = 2'h3;
  localparam logic [1:0]       ARB_LSB     = 2'h0;

  // acknowledge cycle encodings
  localparam logic [2:0]  FC_CPU_SPACE = 3'h7;
  localparam logic [3:0]  ADDR_TOP     = 4'hf;
  localparam logic [3:0]  ADDR_IACK    = 4'hf;
  localparam logic [11:0] ADDR_MID     = 12'hfff;
  localparam logic        ADDR_LSB     = 1'h1;
  localparam logic [LVL_W-1:0] LVL_NONE = 3'h0;
  localparam logic [LVL_W-1:0] LVL_NMI  = 3'h7;

  // vector numbers and address forming
  localparam logic [VEC_W-1:0] VEC_AUTO_BASE = 8'h18;
  localparam logic [VEC_W-1:0] VEC_SPURIOUS  = 8'h18;
  localparam logic [1:0]       VADR_LSBS     = 2'h0;

  // chip-select space code for acknowledge cycles
  localparam logic [1:0] CS_SPACE_IACK = 2'h0;

  // bus monitor time for the external responder
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned BUS_MON_NS    = 1000;
  localparam int unsigned BUS_MON_CYC   = BUS_MON_NS / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 8;

  // acknowledge sequencer, one-hot
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001,
    S_BOUND = 9'h002,
    S_STACK = 9'h004,
    S_ACK   = 9'h008,
    S_ARB   = 9'h010,
    S_RES   = 9'h020,
    S_EXT   = 9'h040,
    S_VEC   = 9'h080,
    S_LOAD  = 9'h100
  } iaa_state_t;

endpackage

// ==== rtl/iaa_interrupt_ack_arbitration.sv ====
module iaa_interrupt_ack_arbitration (
  // clock and reset
  input  wire logic                                       clk,
  input  wire logic                                       rst_b,
  // internal module requests and vectors
  input  wire logic [iaa_pkg::N_MOD-1:0][iaa_pkg::LVL_W-1:0] mod_req_level,
  input  wire logic [iaa_pkg::N_MOD-1:0][iaa_pkg::VEC_W-1:0] mod_vector,
  // periodic interrupt timer request
  input  wire logic [iaa_pkg::LVL_W-1:0]                  pit_req_level,
  input  wire logic [iaa_pkg::VEC_W-1:0]                  pit_vector,
  // external request level from the external bus interface
  input  wire logic [iaa_pkg::LVL_W-1:0]                  ext_req_level,
  // arbitration field write port, index N_MOD is the integration module
  input  wire logic                                       arb_wr_en,
  input  wire logic [2:0]                                 arb_wr_idx,
  input  wire logic [iaa_pkg::ARB_W-1:0]                  arb_wr_data,
  // chip-select autovector option
  input  wire logic [1:0]                                 cs_space,
  input  wire logic                                       cs_autovector_en,
  // processor sequencing
  input  wire logic                                       boundary_reached,
  // external acknowledge responses
  input  wire logic                                       data_size_ack,
  input  wire logic [iaa_pkg::VEC_W-1:0]                  ext_vector,
  input  wire logic                                       autovector_request,
  input  wire logic                                       bus_error,
  // acknowledge cycle outputs
  output logic [2:0]                                      function_code_lines,
  output logic [iaa_pkg::ADDR_W-1:0]                      ack_address,
  output logic                                            ack_cycle_active,
  output logic                                            ext_ack_cycle,
  output logic [iaa_pkg::N_MOD-1:0]                       mod_ack,
  output logic                                            pit_ack,
  // processor side results
  output logic                                            stack_save,
  output logic [iaa_pkg::LVL_W-1:0]                       interrupt_priority_field,
  output logic [iaa_pkg::VEC_W-1:0]                       vector_number,
  output logic                                            spurious,
  output logic                                            spurious_bus_error,
  output logic [iaa_pkg::VADR_W-1:0]                      vector_address,
  output logic                                            pc_load,
  // arbitration field readback
  output logic [iaa_pkg::N_SRC-1:0][iaa_pkg::ARB_W-1:0]   arb_field
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // larger of two levels
  function automatic logic [iaa_pkg::LVL_W-1:0] lvl_max(
    input logic [iaa_pkg::LVL_W-1:0] a,
    input logic [iaa_pkg::LVL_W-1:0] b
  );
    lvl_max = (a > b) ? a : b;
  endfunction

  // a live request at exactly the acknowledged level
  function automatic logic lvl_hit(
    input logic [iaa_pkg::LVL_W-1:0] lvl,
    input logic [iaa_pkg::LVL_W-1:0] ack
  );
    lvl_hit = (lvl == ack) && (lvl != iaa_pkg::LVL_NONE);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_q;
  logic rst_sync_q;

  // async assert, release through two flops so the fsm leaves reset cleanly
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  iaa_pkg::iaa_state_t                               state_q, state_d;
  logic [iaa_pkg::N_SRC-1:0][iaa_pkg::ARB_W-1:0]     arb_q;
  logic [iaa_pkg::N_SRC-1:0]                         alive_q, alive_d;
  logic [1:0]                                        bit_q, bit_d;
  logic [iaa_pkg::LVL_W-1:0]                         lvl_q, lvl_d;
  logic [iaa_pkg::TMR_W-1:0]                         tmr_q, tmr_d;
  logic [iaa_pkg::LVL_W-1:0]                         ipf_q, ipf_d;
  logic [iaa_pkg::VEC_W-1:0]                         vec_q, vec_d;
  logic [2:0]                                        fc_q, fc_d;
  logic [iaa_pkg::ADDR_W-1:0]                        addr_q, addr_d;
  logic                                              act_q, act_d;
  logic                                              ext_q, ext_d;
  logic [iaa_pkg::N_MOD-1:0]                         mack_q, mack_d;
  logic                                              pack_q, pack_d;
  logic                                              stk_q, stk_d;
  logic                                              spur_q, spur_d;
  logic                                              bus_error_q, bus_error_d;
  logic [iaa_pkg::VADR_W-1:0]                        vadr_q, vadr_d;
  logic                                              pcl_q, pcl_d;

  ////////////////////////////////////////////////////////////////////////////
  // pending request detection

  logic [iaa_pkg::LVL_W-1:0] mod_max;
  logic [iaa_pkg::LVL_W-1:0] top_lvl;
  logic                      pend_ok;

  // highest live level; level 7 cannot be masked
  always_comb begin
    mod_max = iaa_pkg::LVL_NONE;
    for (int i = 0; i < iaa_pkg::N_MOD; i++) begin
      mod_max = lvl_max(mod_max, mod_req_level[i]);
    end
  end
  assign top_lvl = lvl_max(mod_max, lvl_max(pit_req_level, ext_req_level));
  assign pend_ok = (top_lvl > ipf_q) || (top_lvl == iaa_pkg::LVL_NMI);

  ////////////////////////////////////////////////////////////////////////////
  // contention decode

  logic [iaa_pkg::N_SRC-1:0] contend;
  logic [iaa_pkg::N_SRC-1:0] cur_bit;
  logic                      any_one;
  logic                      pit_hit;
  logic                      ext_hit;

  // only sources at the acknowledged level join; the sim field stands in
  // for both the periodic timer and the external requesters
  assign pit_hit = lvl_hit(pit_req_level, lvl_q);
  assign ext_hit = lvl_hit(ext_req_level, lvl_q);
  generate
    for (genvar g = 0; g < iaa_pkg::N_MOD; g++) begin : g_src
      assign contend[g] = lvl_hit(mod_req_level[g], lvl_q);
      assign cur_bit[g] = arb_q[g][bit_q];
    end
  endgenerate
  assign contend[iaa_pkg::SIM_IX] = pit_hit | ext_hit;
  assign cur_bit[iaa_pkg::SIM_IX] = arb_q[iaa_pkg::SIM_IX][bit_q];
  assign any_one = |(alive_q & cur_bit);

  // lowest surviving index; equal fields are a software fault and the
  // first survivor is taken so the hardware stays deterministic
  logic [2:0]                win_ix;
  logic [iaa_pkg::ARB_W-1:0] win_field;
  always_comb begin
    win_ix = 3'h0;
    for (int i = iaa_pkg::N_SRC - 1; i >= 0; i--) begin
      if (alive_q[i]) begin
        win_ix = 3'(i);
      end
    end
  end
  assign win_field = arb_q[win_ix];

  logic                      cs_auto;
  logic [iaa_pkg::VEC_W-1:0] auto_vec;
  logic                      tmr_done;

  assign cs_auto  = (cs_space == iaa_pkg::CS_SPACE_IACK) && cs_autovector_en;
  assign auto_vec = iaa_pkg::VEC_AUTO_BASE + {5'h00, lvl_q};
  assign tmr_done = (tmr_q == iaa_pkg::TMR_W'(iaa_pkg::BUS_MON_CYC - 1));

  ////////////////////////////////////////////////////////////////////////////
  // arbitration field registers

  // the sim field comes up winning, every module field comes up silent
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      for (int i = 0; i < iaa_pkg::N_MOD; i++) begin
        arb_q[i] <= iaa_pkg::ARB_MOD_RST;
      end
      arb_q[iaa_pkg::SIM_IX] <= iaa_pkg::ARB_SIM_RST;
    end else if (arb_wr_en && (arb_wr_idx < 3'(iaa_pkg::N_SRC))) begin
      arb_q[arb_wr_idx] <= arb_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge sequencer

  always_comb begin
    state_d = state_q;
    alive_d = alive_q;
    bit_d   = bit_q;
    lvl_d   = lvl_q;
    tmr_d   = tmr_q;
    ipf_d   = ipf_q;
    vec_d   = vec_q;
    fc_d    = fc_q;
    addr_d  = addr_q;
    act_d   = act_q;
    ext_d   = ext_q;
    mack_d  = '0;
    pack_d  = 1'b0;
    stk_d   = 1'b0;
    spur_d  = 1'b0;
    bus_error_d  = 1'b0;
    vadr_d  = vadr_q;
    pcl_d   = 1'b0;
    case (state_q)
      iaa_pkg::S_IDLE: begin
        if (pend_ok) begin
          lvl_d   = top_lvl;
          state_d = iaa_pkg::S_BOUND;
        end
      end
      // wait for the processor to reach a point where it may be interrupted
      iaa_pkg::S_BOUND: begin
        if (boundary_reached) begin
          stk_d   = 1'b1;
          state_d = iaa_pkg::S_STACK;
        end
      end
      // status and pc saved; now present the acknowledge cycle
      iaa_pkg::S_STACK: begin
        fc_d    = iaa_pkg::FC_CPU_SPACE;
        addr_d  = {iaa_pkg::ADDR_TOP, iaa_pkg::ADDR_IACK, iaa_pkg::ADDR_MID,
                   lvl_q, iaa_pkg::ADDR_LSB};
        act_d   = 1'b1;
        state_d = iaa_pkg::S_ACK;
      end
      // level taken back from the address lines, contention starts
      iaa_pkg::S_ACK: begin
        ipf_d   = addr_q[3:1];
        alive_d = contend;
        bit_d   = iaa_pkg::ARB_MSB;
        if (contend == '0) begin
          spur_d  = 1'b1;
          bus_error_d  = 1'b1;
          vec_d   = iaa_pkg::VEC_SPURIOUS;
          state_d = iaa_pkg::S_VEC;
        end else begin
          state_d = iaa_pkg::S_ARB;
        end
      end
      // one field bit per cycle, msb first; a 1 knocks out the 0s
      iaa_pkg::S_ARB: begin
        if (any_one) begin
          alive_d = alive_q & cur_bit;
        end
        if (bit_q == iaa_pkg::ARB_LSB) begin
          state_d = iaa_pkg::S_RES;
        end else begin
          bit_d = bit_q - 2'h1;
        end
      end
      iaa_pkg::S_RES: begin
        if (win_field == iaa_pkg::ARB_NONE) begin
          spur_d  = 1'b1;
          vec_d   = iaa_pkg::VEC_SPURIOUS;
          state_d = iaa_pkg::S_VEC;
        end else if (win_ix != 3'(iaa_pkg::SIM_IX)) begin
          mack_d[win_ix[1:0]] = 1'b1;
          vec_d   = mod_vector[win_ix[1:0]];
          state_d = iaa_pkg::S_VEC;
        end else if (pit_hit) begin
          pack_d  = 1'b1;
          vec_d   = pit_vector;
          state_d = iaa_pkg::S_VEC;
        end else if (cs_auto) begin
          vec_d   = auto_vec;
          state_d = iaa_pkg::S_VEC;
        end else begin
          ext_d   = 1'b1;
          tmr_d   = '0;
          state_d = iaa_pkg::S_EXT;
        end
      end
      // external cycle: a responder answers or the bus monitor ends it
      iaa_pkg::S_EXT: begin
        tmr_d = tmr_q + iaa_pkg::TMR_W'(1);
        if (data_size_ack) begin
          vec_d   = ext_vector;
          state_d = iaa_pkg::S_VEC;
        end else if (autovector_request) begin
          vec_d   = auto_vec;
          state_d = iaa_pkg::S_VEC;
        end else if (bus_error || tmr_done) begin
          spur_d  = 1'b1;
          bus_error_d  = 1'b1;
          vec_d   = iaa_pkg::VEC_SPURIOUS;
          state_d = iaa_pkg::S_VEC;
        end
      end
      // cycle over; form the vector address
      iaa_pkg::S_VEC: begin
        act_d   = 1'b0;
        ext_d   = 1'b0;
        fc_d    = '0;
        addr_d  = '0;
        vadr_d  = {vec_q, iaa_pkg::VADR_LSBS};
        state_d = iaa_pkg::S_LOAD;
      end
      iaa_pkg::S_LOAD: begin
        pcl_d   = 1'b1;
        state_d = iaa_pkg::S_IDLE;
      end
      default: begin
        state_d = iaa_pkg::S_IDLE;
        act_d   = 1'b0;
        ext_d   = 1'b0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q <= iaa_pkg::S_IDLE;
      alive_q <= '0;
      bit_q   <= '0;
      lvl_q   <= '0;
      tmr_q   <= '0;
      ipf_q   <= '0;
      vec_q   <= '0;
      fc_q    <= '0;
      addr_q  <= '0;
      act_q   <= 1'b0;
      ext_q   <= 1'b0;
      mack_q  <= '0;
      pack_q  <= 1'b0;
      stk_q   <= 1'b0;
      spur_q  <= 1'b0;
      bus_error_q  <= 1'b0;
      vadr_q  <= '0;
      pcl_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      alive_q <= alive_d;
      bit_q   <= bit_d;
      lvl_q   <= lvl_d;
      tmr_q   <= tmr_d;
      ipf_q   <= ipf_d;
      vec_q   <= vec_d;
      fc_q    <= fc_d;
      addr_q  <= addr_d;
      act_q   <= act_d;
      ext_q   <= ext_d;
      mack_q  <= mack_d;
      pack_q  <= pack_d;
      stk_q   <= stk_d;
      spur_q  <= spur_d;
      bus_error_q  <= bus_error_d;
      vadr_q  <= vadr_d;
      pcl_q   <= pcl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign function_code_lines      = fc_q;
  assign ack_address              = addr_q;
  assign ack_cycle_active         = act_q;
  assign ext_ack_cycle            = ext_q;
  assign mod_ack                  = mack_q;
  assign pit_ack                  = pack_q;
  assign stack_save               = stk_q;
  assign interrupt_priority_field = ipf_q;
  assign vector_number            = vec_q;
  assign spurious                 = spur_q;
  assign spurious_bus_error       = bus_error_q;
  assign vector_address           = vadr_q;
  assign pc_load                  = pcl_q;
  assign arb_field                = arb_q;

endmodule

// ==== tb/iaa_properties.sv ====
module iaa_properties (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // arbitration field writes
  input wire logic                 arb_wr_en,
  input wire logic [2:0]           arb_wr_idx,
  input wire logic [3:0]           arb_wr_data,
  input wire logic [4:0][3:0]      arb_field,
  // acknowledge cycle
  input wire logic [2:0]           function_code_lines,
  input wire logic [23:0]          ack_address,
  input wire logic                 ack_cycle_active,
  input wire logic                 ext_ack_cycle,
  input wire logic [3:0]           mod_ack,
  input wire logic                 pit_ack,
  // processor side results
  input wire logic                 stack_save,
  input wire logic [2:0]           interrupt_priority_field,
  input wire logic [7:0]           vector_number,
  input wire logic                 spurious,
  input wire logic                 spurious_bus_error,
  input wire logic [9:0]           vector_address,
  input wire logic                 pc_load
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////
  // length of the external cycle, so a missing bus monitor shows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 8'h00;
    end else begin
      wait_q <= ext_ack_cycle ? wait_q + 8'h01 : 8'h00;
    end
  end

  // acknowledge cycle shape and outcome
  a_fc_cpu_space: assert property (
    ack_cycle_active |-> function_code_lines == iaa_pkg::FC_CPU_SPACE)
    else $error("function code wrong in ack cycle");
  a_ack_addr_ones: assert property (
    ack_cycle_active |-> ack_address[23:4] == 20'hfffff && ack_address[0])
    else $error("ack address not all ones");
  a_ipf_from_addr: assert property (
    $rose(ack_cycle_active) |-> ##[1:2] interrupt_priority_field == ack_address[3:1])
    else $error("priority field not latched from address");
  a_stack_then_ack: assert property (
    stack_save |=> ack_cycle_active)
    else $error("ack cycle did not follow stacking");
  a_vec_to_addr: assert property (
    pc_load |-> vector_address == {vector_number, iaa_pkg::VADR_LSBS})
    else $error("vector address wrong at pc load");
  a_spur_vec_num: assert property (
    spurious |-> ##[0:1] vector_number == iaa_pkg::VEC_SPURIOUS)
    else $error("spurious vector wrong");
  a_bus_error_is_spur: assert property (
    spurious_bus_error |-> spurious)
    else $error("bus error without spurious");
  a_ext_sim_won: assert property (
    ext_ack_cycle |-> ack_cycle_active && mod_ack == 4'h0 && !pit_ack)
    else $error("external cycle while internal source won");
  a_one_winner: assert property (
    $onehot0({pit_ack, mod_ack}))
    else $error("more than one winner acknowledged");
  a_ext_bus_mon: assert property (
    wait_q <= 8'd130)
    else $error("external cycle outlived bus monitor");
  a_arb_written: assert property (
    arb_wr_en && arb_wr_idx <= 3'h4 |=> arb_field[$past(arb_wr_idx)] == $past(arb_wr_data))
    else $error("arbitration field write lost");

  // main outcomes reached
  c_vectored: cover property (pc_load && !spurious);
  c_external: cover property (ext_ack_cycle ##1 !ext_ack_cycle);
  c_bus_error: cover property (spurious_bus_error);
endmodule

bind iaa_interrupt_ack_arbitration iaa_properties u_props (
  .clk, .rst_b, .arb_wr_en, .arb_wr_idx, .arb_wr_data, .arb_field, .function_code_lines,
  .ack_address, .ack_cycle_active, .ext_ack_cycle, .mod_ack, .pit_ack, .stack_save,
  .interrupt_priority_field, .vector_number, .spurious, .spurious_bus_error,
  .vector_address, .pc_load
);

// ==== tb/iaa_ext_responder.sv ====
module iaa_ext_responder (
  // clock
  input wire logic        clk,
  // external acknowledge cycle from the block
  input wire logic        ext_ack_cycle,
  input wire logic [23:0] ack_address,
  // behaviour: 0 vector, 1 autovector, 2 bus error, 3 silent
  input wire logic [2:0]  req_level,
  input wire logic [1:0]  mode,
  input wire logic [2:0]  delay,
  input wire logic [7:0]  vec,
  // request and termination back to the block
  output logic [2:0]      ext_req_level,
  output logic            data_size_ack,
  output logic [7:0]      ext_vector,
  output logic            autovector_request,
  output logic            bus_error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q;
  logic       answer;

  ////////////////////////////////////////////////////////////////
  // saturating wait count so a silent device stays silent
  always_ff @(posedge clk) begin
    if (!ext_ack_cycle) begin
      wait_q <= 4'h0;
    end else if (wait_q != 4'hf) begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // answer only when our own level is on the address, after the delay
  assign answer = ext_ack_cycle && ack_address[3:1] == req_level
                  && wait_q > {1'b0, delay};
  assign ext_req_level      = req_level;
  assign data_size_ack      = answer && mode == 2'h0;
  assign autovector_request = answer && mode == 2'h1;
  assign bus_error          = answer && mode == 2'h2;
  // released lines show the inverse, a stale vector never matches by luck
  assign ext_vector         = data_size_ack ? vec : ~vec;
endmodule

// ==== tb/iaa_interrupt_ack_arbitration_bench.sv ====
module iaa_interrupt_ack_arbitration_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk, rst_b, arb_wr_en, cs_autovector_en, boundary_reached, data_size_ack;
  logic            autovector_request, bus_error, ack_cycle_active, ext_ack_cycle, pit_ack;
  logic            stack_save, spurious, spurious_bus_error, pc_load, seen;
  logic [1:0]      cs_space, rsp_mode;
  logic [2:0]      pit_req_level, ext_req_level, interrupt_priority_field, arb_wr_idx;
  logic [2:0]      function_code_lines, rsp_level, rsp_delay, lvl;
  logic [3:0]      arb_wr_data, mod_ack;
  logic [7:0]      pit_vector, ext_vector, vector_number, rsp_vec;
  logic [9:0]      vector_address;
  logic [23:0]     ack_address;
  logic [31:0]     seed;
  logic [3:0][2:0] mod_req_level;
  logic [3:0][7:0] mod_vector;
  logic [4:0][3:0] arb_field;
  logic [3:0]      fld [5];
  int              n_mismatch, total_checks, w;

  iaa_interrupt_ack_arbitration u_dut (
    .clk, .rst_b, .mod_req_level, .mod_vector, .pit_req_level, .pit_vector, .ext_req_level,
    .arb_wr_en, .arb_wr_idx, .arb_wr_data, .cs_space, .cs_autovector_en, .boundary_reached,
    .data_size_ack, .ext_vector, .autovector_request, .bus_error, .function_code_lines,
    .ack_address, .ack_cycle_active, .ext_ack_cycle, .mod_ack, .pit_ack, .stack_save,
    .interrupt_priority_field, .vector_number, .spurious, .spurious_bus_error,
    .vector_address, .pc_load, .arb_field
  );
  iaa_ext_responder u_resp (
    .clk, .ext_ack_cycle, .ack_address, .req_level(rsp_level), .mode(rsp_mode),
    .delay(rsp_delay), .vec(rsp_vec), .ext_req_level, .data_size_ack, .ext_vector,
    .autovector_request, .bus_error
  );

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // highest field among requesters, ties to the lowest index
  function automatic int winner(input logic [4:0] m);
    int r;
    r = 0;
    for (int i = 0; i < 5; i++)
      if (m[i] && (!m[r] || fld[i] > fld[r])) r = i;
    return r;
  endfunction
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    mod_req_level = '0;
    pit_req_level = 3'h0;
    rsp_level = 3'h0;
    boundary_reached = 1'b0;
    cs_autovector_en = 1'b0;
    cs_space = 2'h1;
    fld = '{4'h0, 4'h0, 4'h0, 4'h0, 4'hf};
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // writes stay back to back; caller drops the enable afterwards
  task automatic wr_arb(input logic [2:0] idx, input logic [3:0] d);
    arb_wr_en = 1'b1;
    arb_wr_idx = idx;
    arb_wr_data = d;
    if (idx < 3'h5) fld[idx] = d;
    @(posedge clk);
    #1;
  endtask
  // one full acknowledge, ending one idle edge later so callers may drive again
  task automatic run_ack(input logic [2:0] l, input logic [7:0] ev, input logic [4:0] ew,
                         input logic [2:0] ef);
    logic [4:0] who;
    logic [2:0] flg;
    logic       sn;
    who = '0;
    flg = '0;
    sn = 1'b0;
    boundary_reached = 1'b1;
    for (int n = 0; n < 400 && pc_load !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      who = who | {pit_ack, mod_ack};
      flg = flg | {ext_ack_cycle, spurious_bus_error, spurious};
      if (ack_cycle_active === 1'b1 && !sn) begin
        sn = 1'b1;
        chk(ack_address, {20'hfffff, l, 1'b1});
        chk(function_code_lines, 3'h7);
      end
    end
    chk(pc_load, 1'b1);
    chk(vector_number, ev);
    chk(vector_address, {ev, 2'h0});
    chk(interrupt_priority_field, l);
    chk(flg, ef);
    if (!ef[0]) chk(who, ew);
    boundary_reached = 1'b0;
    mod_req_level = '0;
    pit_req_level = 3'h0;
    rsp_level = 3'h0;
    @(posedge clk);
    #1 $display("test done at %0t", $time);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // about eighteen acknowledges of at most a few hundred cycles each
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  initial begin
    seed = 32'hcf87;
    {arb_wr_en, arb_wr_idx, arb_wr_data, mod_vector, pit_vector} = '0;
    {rsp_mode, rsp_delay, rsp_vec} = '0;
    do_reset();
    // reset values; a write to an unused index changes nothing
    chk(arb_field, {4'hf, 16'h0000});
    chk({ack_cycle_active, stack_save, pc_load, function_code_lines}, 32'h0);
    wr_arb(3'h6, 4'h5);
    arb_wr_en = 1'b0;
    chk(arb_field, {4'hf, 16'h0000});
    // random distinct fields, all four modules at one level
    for (int t = 0; t < 6; t++) begin
      do_reset();
      seed = xs(seed);
      for (int i = 0; i < 4; i++)
        wr_arb(3'(i), 4'h1 + 4'((seed[3:0] + 3 * i) % 15));
      arb_wr_en = 1'b0;
      chk(arb_field, {fld[4], fld[3], fld[2], fld[1], fld[0]});
      lvl = seed[6:4] == 3'h0 ? 3'h4 : seed[6:4];
      mod_req_level = {4{lvl}};
      mod_vector = xs(seed);
      w = winner(5'h0f);
      run_ack(lvl, mod_vector[w], 5'h01 << w, 3'b000);
    end
    // field 0 winner, then a request withdrawn before contention
    do_reset();
    mod_req_level[2] = 3'h3;
    run_ack(3'h3, iaa_pkg::VEC_SPURIOUS, 5'h00, 3'b001);
    do_reset();
    mod_req_level[0] = 3'h5;
    repeat (3) @(posedge clk);
    #1 mod_req_level[0] = 3'h0;
    run_ack(3'h5, iaa_pkg::VEC_SPURIOUS, 5'h00, 3'b011);
    // timer beats external at the same level
    do_reset();
    wr_arb(3'h0, 4'h2);
    arb_wr_en = 1'b0;
    mod_req_level[0] = 3'h4;
    pit_req_level = 3'h4;
    rsp_level = 3'h4;
    pit_vector = seed[23:16];
    run_ack(3'h4, pit_vector, 5'h10, 3'b000);
    // every external termination, then the integration module losing
    for (int m = 0; m < 5; m++) begin
      do_reset();
      seed = xs(seed);
      lvl = seed[2:0] == 3'h0 ? 3'h3 : seed[2:0];
      wr_arb(3'h1, 4'h9);
      if (m == 4) wr_arb(3'h4, 4'h3);
      arb_wr_en = 1'b0;
      mod_req_level[1] = lvl;
      mod_vector = seed;
      rsp_level = lvl;
      rsp_mode = 2'(m);
      rsp_delay = seed[10:8];
      rsp_vec = seed[23:16];
      case (m)
        0: run_ack(lvl, rsp_vec, 5'h00, 3'b100);
        1: run_ack(lvl, iaa_pkg::VEC_AUTO_BASE + 8'(lvl), 5'h00, 3'b100);
        2: run_ack(lvl, iaa_pkg::VEC_SPURIOUS, 5'h00, 3'b111);
        3: run_ack(lvl, iaa_pkg::VEC_SPURIOUS, 5'h00, 3'b111);
        default: run_ack(lvl, mod_vector[1], 5'h02, 3'b000);
      endcase
    end
    // chip-select autovector on and off
    do_reset();
    cs_space = iaa_pkg::CS_SPACE_IACK;
    cs_autovector_en = 1'b1;
    rsp_level = 3'h6;
    rsp_mode = 2'h3;
    run_ack(3'h6, iaa_pkg::VEC_AUTO_BASE + 8'h06, 5'h00, 3'b000);
    cs_space = 2'h1;
    rsp_level = 3'h7;
    rsp_mode = 2'h0;
    run_ack(3'h7, rsp_vec, 5'h00, 3'b100);
    // masked level ignored, level 7 still taken
    do_reset();
    wr_arb(3'h0, 4'h5);
    arb_wr_en = 1'b0;
    mod_req_level[0] = 3'h5;
    run_ack(3'h5, mod_vector[0], 5'h01, 3'b000);
    mod_req_level[1] = 3'h3;
    boundary_reached = 1'b1;
    seen = 1'b0;
    repeat (30) begin
      @(posedge clk);
      #1 seen = seen | stack_save;
    end
    chk(seen, 1'b0);
    mod_req_level[0] = 3'h7;
    run_ack(3'h7, mod_vector[0], 5'h01, 3'b000);
    results();
  end
endmodule
